// ### core/afe_setup_pkg.sv
package afe_setup_pkg;

   // ************************************************************
   // Register indices (byte address = 4 * index)
   // ************************************************************
   localparam logic [5:0] IDX_OUTPUT_FORMAT = 6'h02;
   localparam logic [5:0] IDX_CLAMP_CHANNEL = 6'h03;
   localparam logic [5:0] IDX_DEVICE_RESET  = 6'h04;
   localparam logic [5:0] IDX_CYCLE_RESET   = 6'h05;
   localparam logic [5:0] IDX_LINE_MODE     = 6'h06;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int unsigned OF_FORMAT_LSB     = 0;
   localparam int unsigned OF_INVERT_BIT     = 2;
   localparam int unsigned OF_CLAMP_EXT_BIT  = 3;
   localparam int unsigned OF_DAC_RANGE_BIT  = 5;
   localparam int unsigned OF_LATENCY_LSB    = 6;
   localparam int unsigned CC_LEVEL_LSB      = 0;
   localparam int unsigned CC_ADJUST_LSB     = 4;
   localparam int unsigned CC_CHANNEL_LSB    = 6;
   localparam int unsigned LM_LINE_SEQ_BIT   = 0;
   localparam int unsigned LM_AUTO_CYCLE_BIT = 1;
   localparam int unsigned LM_MODE3_BIT      = 2;

   // ************************************************************
   // Reset values and writable masks
   // ************************************************************
   localparam logic [7:0] OUTPUT_FORMAT_RST  = 8'h20;
   localparam logic [7:0] OUTPUT_FORMAT_MASK = 8'hef;
   localparam logic [7:0] CLAMP_CHANNEL_RST  = 8'h1f;
   localparam logic [7:0] LINE_MODE_RST      = 8'h00;
   localparam logic [7:0] LINE_MODE_MASK     = 8'h07;

   // ************************************************************
   // Timing counts in master clock periods
   // ************************************************************
   localparam logic [3:0] ADC_PERIOD_NORMAL = 4'h2;
   localparam logic [3:0] ADC_PERIOD_MODE3  = 4'h3;
   localparam int unsigned MAX_DELAY        = 9;

   typedef enum logic [1:0] {FMT_PARALLEL, FMT_BYTE_A, FMT_BYTE_B, FMT_NIBBLE} out_format_type;
   typedef enum logic [1:0] {COLOUR_RED, COLOUR_GREEN, COLOUR_BLUE} colour_type;

endpackage

// ### core/afe_latency_line.sv
`timescale 1ns/1ps
module afe_latency_line #(
   parameter int unsigned WIDTH = 17,
   parameter int unsigned DEPTH = 9
) (
   input  wire logic                       clk_i,
   input  wire logic                       rst_b_i,
   input  wire logic                       clear_i,
   input  wire logic [WIDTH-1:0]           data_i,
   input  wire logic [$clog2(DEPTH+1)-1:0] tap_i,
   output logic      [WIDTH-1:0]           data_o
);
   logic [WIDTH-1:0] stage_ff [DEPTH];

   // ************************************************************
   // Shift line, tap 0 is a straight bypass
   // ************************************************************
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int i = 0; i < DEPTH; i++) stage_ff[i] <= '0;
      end else if (clear_i) begin
         for (int i = 0; i < DEPTH; i++) stage_ff[i] <= '0;
      end else begin
         stage_ff[0] <= data_i;
         for (int i = 1; i < DEPTH; i++) stage_ff[i] <= stage_ff[i-1];
      end
   end

   assign data_o = (tap_i == '0) ? data_i : stage_ff[tap_i - 1'b1];

endmodule // afe_latency_line

// ### core/afe_output_and_clamp_setup.sv
// What this block does
// RULE_01: Format field picks parallel, byte or nibble output
// RULE_02: Invert bit digitally inverts output data
// RULE_03: External clamp bit powers down clamp DAC
// RULE_04: Range bit picks DAC full scale, default one
// RULE_05: Latency field adds zero to three converter periods
// RULE_06: Converter period two clocks, three in mode three
// RULE_07: Four-bit clamp code, default all ones
// RULE_08: Reset sample adjust field, default normal
// RULE_09: Mono channel field picks red, green, blue
// RULE_10: Any write to reset location resets everything
// RULE_11: Host resets device before other writes
// RULE_12: Any cycle reset write returns counter to red
// RULE_13: Pin pulses advance counter when auto-cycling
// RULE_14: Line mode forces mono, channel red, gains off
// RULE_15: Host never writes reserved channel code
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module afe_output_and_clamp_setup (
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic             pready_o,
   output logic      [31:0] prdata_o,
   output logic             pslverr_o,
   input  wire logic [15:0] sample_i,
   input  wire logic        sample_valid_i,
   input  wire logic        mono_request_i,
   input  wire logic        clamp_or_cycle_pin_i,
   output logic      [15:0] data_o,
   output logic             data_valid_o,
   output logic             word_start_o,
   output logic      [3:0]  clamp_level_code_o,
   output logic             clamp_dac_enable_o,
   output logic             clamp_dac_range_o,
   output logic      [1:0]  reset_sample_adjust_o,
   output logic             mono_mode_o,
   output logic      [1:0]  mono_channel_o,
   output logic             green_blue_gain_en_o,
   output logic      [1:0]  colour_sel_o,
   output logic             clamp_pulse_o,
   output logic             device_reset_o
);
   // ************************************************************
   // Functions
   // ************************************************************
   function automatic logic [3:0] delay_cycles(input logic [1:0] lat, input logic mode3);
      logic [3:0] period;
      period = mode3 ? afe_setup_pkg::ADC_PERIOD_MODE3 : afe_setup_pkg::ADC_PERIOD_NORMAL; // RULE_06
      return 4'(lat * period); // RULE_05
   endfunction

   // ************************************************************
   // Register bus decode
   // ************************************************************
   logic [7:0] output_format_ff, nxt_output_format;
   logic [7:0] clamp_channel_ff, nxt_clamp_channel;
   logic [7:0] line_mode_ff,     nxt_line_mode;
   logic       pready_ff, pslverr_ff;
   logic [31:0] prdata_ff;

   wire [5:0] reg_idx   = paddr_i[7:2];
   wire       hit_fmt   = (reg_idx == afe_setup_pkg::IDX_OUTPUT_FORMAT);
   wire       hit_clamp = (reg_idx == afe_setup_pkg::IDX_CLAMP_CHANNEL);
   wire       hit_dev   = (reg_idx == afe_setup_pkg::IDX_DEVICE_RESET);
   wire       hit_cyc   = (reg_idx == afe_setup_pkg::IDX_CYCLE_RESET);
   wire       hit_line  = (reg_idx == afe_setup_pkg::IDX_LINE_MODE);
   wire       mapped    = hit_fmt | hit_clamp | hit_dev | hit_cyc | hit_line;
   wire       access    = psel_i & penable_i;
   wire       commit    = access & pready_ff;
   wire       wr_en     = commit & pwrite_i & mapped;
   wire       soft_rst  = wr_en & hit_dev; // RULE_10
   wire       cyc_rst   = wr_en & hit_cyc; // RULE_12
   wire [7:0] wbyte     = pwdata_i[7:0];

   wire [7:0] rd_byte = hit_fmt   ? output_format_ff :
                        hit_clamp ? clamp_channel_ff :
                        hit_line  ? line_mode_ff     : 8'h00;

   assign nxt_output_format = soft_rst              ? afe_setup_pkg::OUTPUT_FORMAT_RST :
                              (wr_en && hit_fmt)    ? (wbyte & afe_setup_pkg::OUTPUT_FORMAT_MASK) :
                              output_format_ff;
   assign nxt_clamp_channel = soft_rst              ? afe_setup_pkg::CLAMP_CHANNEL_RST :
                              (wr_en && hit_clamp)  ? wbyte : clamp_channel_ff;
   assign nxt_line_mode     = soft_rst              ? afe_setup_pkg::LINE_MODE_RST :
                              (wr_en && hit_line)   ? (wbyte & afe_setup_pkg::LINE_MODE_MASK) :
                              line_mode_ff;

   // One wait state: the answer rises in the second access cycle
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end else begin
         pready_ff  <= access & ~pready_ff;
         pslverr_ff <= access & ~pready_ff & ~mapped;
         prdata_ff  <= (access & ~pready_ff & ~pwrite_i) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         output_format_ff <= afe_setup_pkg::OUTPUT_FORMAT_RST; // RULE_04
         clamp_channel_ff <= afe_setup_pkg::CLAMP_CHANNEL_RST; // RULE_07 RULE_08
         line_mode_ff     <= afe_setup_pkg::LINE_MODE_RST;
      end else begin
         output_format_ff <= nxt_output_format;
         clamp_channel_ff <= nxt_clamp_channel;
         line_mode_ff     <= nxt_line_mode;
      end
   end

   // ************************************************************
   // Field views
   // ************************************************************
   wire [1:0] fmt_sel   = output_format_ff[afe_setup_pkg::OF_FORMAT_LSB +: 2];
   wire       invert    = output_format_ff[afe_setup_pkg::OF_INVERT_BIT];
   wire       clamp_ext = output_format_ff[afe_setup_pkg::OF_CLAMP_EXT_BIT];
   wire       dac_range = output_format_ff[afe_setup_pkg::OF_DAC_RANGE_BIT];
   wire [1:0] latency   = output_format_ff[afe_setup_pkg::OF_LATENCY_LSB +: 2];
   wire [3:0] lvl_code  = clamp_channel_ff[afe_setup_pkg::CC_LEVEL_LSB +: 4];
   wire [1:0] rs_adjust = clamp_channel_ff[afe_setup_pkg::CC_ADJUST_LSB +: 2];
   wire [1:0] chan_sel  = clamp_channel_ff[afe_setup_pkg::CC_CHANNEL_LSB +: 2];
   wire       line_seq  = line_mode_ff[afe_setup_pkg::LM_LINE_SEQ_BIT];
   wire       auto_cyc  = line_seq & line_mode_ff[afe_setup_pkg::LM_AUTO_CYCLE_BIT];
   wire       mode3     = line_mode_ff[afe_setup_pkg::LM_MODE3_BIT];

   // ************************************************************
   // Pin synchroniser and colour auto-cycle counter
   // ************************************************************
   logic pin_meta_ff, pin_sync_ff, pin_last_ff;
   afe_setup_pkg::colour_type colour_ff, nxt_colour;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pin_meta_ff <= 1'b0;
         pin_sync_ff <= 1'b0;
         pin_last_ff <= 1'b0;
      end else begin
         pin_meta_ff <= clamp_or_cycle_pin_i;
         pin_sync_ff <= pin_meta_ff;
         pin_last_ff <= pin_sync_ff;
      end
   end

   wire pin_rise = pin_sync_ff & ~pin_last_ff;
   wire advance  = auto_cyc & pin_rise; // RULE_13

   always_comb begin
      nxt_colour = colour_ff;
      if (soft_rst || cyc_rst) begin
         nxt_colour = afe_setup_pkg::COLOUR_RED; // RULE_12
      end else if (advance) begin
         case (colour_ff)
            afe_setup_pkg::COLOUR_RED:   nxt_colour = afe_setup_pkg::COLOUR_GREEN;
            afe_setup_pkg::COLOUR_GREEN: nxt_colour = afe_setup_pkg::COLOUR_BLUE;
            default:                     nxt_colour = afe_setup_pkg::COLOUR_RED;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) colour_ff <= afe_setup_pkg::COLOUR_RED;
      else          colour_ff <= nxt_colour;
   end

   // ************************************************************
   // Latency line, inversion and output serialiser
   // ************************************************************
   localparam int unsigned TAP_W = $clog2(afe_setup_pkg::MAX_DELAY + 1);
   logic [16:0] dly_word;

   afe_latency_line #(.WIDTH(17), .DEPTH(afe_setup_pkg::MAX_DELAY)) u_latency (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .clear_i (soft_rst),
      .data_i  ({sample_valid_i, sample_i}),
      .tap_i   (TAP_W'(delay_cycles(latency, mode3))), // RULE_05 RULE_06
      .data_o  (dly_word)
   );

   wire        dly_valid = dly_word[16];
   wire [15:0] dly_data  = invert ? ~dly_word[15:0] : dly_word[15:0]; // RULE_02

   logic [15:0] data_ff, shift_ff, nxt_data, nxt_shift;
   logic        valid_ff, start_ff, nxt_valid, nxt_start, nib_ff, nxt_nib;
   logic [1:0]  beats_ff, nxt_beats;

   // A new word cuts short an unfinished one; nibble mode needs four clocks per word
   always_comb begin
      nxt_data  = data_ff;
      nxt_shift = shift_ff;
      nxt_beats = beats_ff;
      nxt_nib   = nib_ff;
      nxt_valid = 1'b0;
      nxt_start = 1'b0;
      if (dly_valid) begin
         nxt_valid = 1'b1;
         nxt_start = 1'b1;
         case (fmt_sel) // RULE_01
            2'b00: begin
               nxt_data  = dly_data;
               nxt_beats = 2'h0;
            end
            2'b11: begin
               nxt_data  = {12'h000, dly_data[15:12]};
               nxt_shift = {dly_data[11:0], 4'h0};
               nxt_beats = 2'h3;
               nxt_nib   = 1'b1;
            end
            default: begin
               nxt_data  = {8'h00, dly_data[15:8]};
               nxt_shift = {dly_data[7:0], 8'h00};
               nxt_beats = 2'h1;
               nxt_nib   = 1'b0;
            end
         endcase
      end else if (beats_ff != 2'h0) begin
         nxt_valid = 1'b1;
         nxt_beats = beats_ff - 2'h1;
         if (nib_ff) begin
            nxt_data  = {12'h000, shift_ff[15:12]};
            nxt_shift = {shift_ff[11:0], 4'h0};
         end else begin
            nxt_data  = {8'h00, shift_ff[15:8]};
            nxt_shift = {shift_ff[7:0], 8'h00};
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         data_ff  <= 16'h0000;
         shift_ff <= 16'h0000;
         beats_ff <= 2'h0;
         nib_ff   <= 1'b0;
         valid_ff <= 1'b0;
         start_ff <= 1'b0;
      end else if (soft_rst) begin
         data_ff  <= 16'h0000;
         shift_ff <= 16'h0000;
         beats_ff <= 2'h0;
         nib_ff   <= 1'b0;
         valid_ff <= 1'b0;
         start_ff <= 1'b0;
      end else begin
         data_ff  <= nxt_data;
         shift_ff <= nxt_shift;
         beats_ff <= nxt_beats;
         nib_ff   <= nxt_nib;
         valid_ff <= nxt_valid;
         start_ff <= nxt_start;
      end
   end

   // ************************************************************
   // Registered analogue controls
   // ************************************************************
   logic [3:0] lvl_ff;
   logic       dac_en_ff, range_ff, mono_ff, gb_en_ff, clamp_ff, dev_rst_ff;
   logic [1:0] adj_ff, chan_ff, colour_sel_ff;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lvl_ff        <= afe_setup_pkg::CLAMP_CHANNEL_RST[afe_setup_pkg::CC_LEVEL_LSB +: 4];
         dac_en_ff     <= 1'b1;
         range_ff      <= afe_setup_pkg::OUTPUT_FORMAT_RST[afe_setup_pkg::OF_DAC_RANGE_BIT];
         adj_ff        <= afe_setup_pkg::CLAMP_CHANNEL_RST[afe_setup_pkg::CC_ADJUST_LSB +: 2];
         mono_ff       <= 1'b0;
         chan_ff       <= 2'h0;
         gb_en_ff      <= 1'b1;
         colour_sel_ff <= 2'h0;
         clamp_ff      <= 1'b0;
         dev_rst_ff    <= 1'b0;
      end else begin
         lvl_ff        <= lvl_code; // RULE_07
         dac_en_ff     <= ~clamp_ext; // RULE_03
         range_ff      <= dac_range; // RULE_04
         adj_ff        <= rs_adjust; // RULE_08
         mono_ff       <= mono_request_i | line_seq; // RULE_14
         chan_ff       <= line_seq ? 2'h0 : chan_sel; // RULE_09 RULE_14
         gb_en_ff      <= ~line_seq; // RULE_14
         colour_sel_ff <= colour_ff;
         clamp_ff      <= pin_sync_ff & ~auto_cyc; // RULE_13
         dev_rst_ff    <= soft_rst; // RULE_10
      end
   end

   assign pready_o              = pready_ff;
   assign prdata_o              = prdata_ff;
   assign pslverr_o             = pslverr_ff;
   assign data_o                = data_ff;
   assign data_valid_o          = valid_ff;
   assign word_start_o          = start_ff;
   assign clamp_level_code_o    = lvl_ff;
   assign clamp_dac_enable_o    = dac_en_ff;
   assign clamp_dac_range_o     = range_ff;
   assign reset_sample_adjust_o = adj_ff;
   assign mono_mode_o           = mono_ff;
   assign mono_channel_o        = chan_ff;
   assign green_blue_gain_en_o  = gb_en_ff;
   assign colour_sel_o          = colour_sel_ff;
   assign clamp_pulse_o         = clamp_ff;
   assign device_reset_o        = dev_rst_ff;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   a_bus_answer_once:  assert property (access && !pready_ff |=> pready_o ##1 !pready_o)
      else $error("APB answer not a single cycle");
   a_unmapped_error:   assert property (access && !pready_ff && !mapped |=> pslverr_o && pready_o)
      else $error("Unmapped access without error");
   a_soft_reset_all:   assert property (soft_rst |=> output_format_ff == 8'h20 && clamp_channel_ff == 8'h1f
                                        && device_reset_o) // RULE_10
      else $error("Software reset did not restore defaults");
   a_cycle_to_red:     assert property (cyc_rst |=> colour_ff == afe_setup_pkg::COLOUR_RED ##1 colour_sel_o == 2'h0) // RULE_12
      else $error("Cycle reset did not return to red");
   a_cycle_advance:    assert property (advance && !soft_rst && !cyc_rst && colour_ff == afe_setup_pkg::COLOUR_GREEN
                                        |=> colour_ff == afe_setup_pkg::COLOUR_BLUE) // RULE_13
      else $error("Counter did not advance on pin pulse");
   a_line_forces_mono: assert property (line_seq |=> mono_mode_o && mono_channel_o == 2'h0 && !green_blue_gain_en_o) // RULE_14
      else $error("Line mode did not force mono red");
   a_dac_power_down:   assert property (clamp_ext |=> !clamp_dac_enable_o) // RULE_03
      else $error("Clamp DAC not powered down");
   a_parallel_invert:  assert property (dly_valid && fmt_sel == 2'b00 && !soft_rst
                                        |=> data_valid_o && data_o == ($past(invert) ? ~$past(dly_word[15:0])
                                                                                      : $past(dly_word[15:0]))) // RULE_01 RULE_02
      else $error("Parallel output word wrong");
   a_byte_pair:        assert property (dly_valid && fmt_sel == 2'b01 && !soft_rst ##1 !dly_valid && !soft_rst
                                        |=> data_valid_o && data_o[15:8] == 8'h00) // RULE_01
      else $error("Second byte of pair missing");
   a_latency_taps:     assert property (delay_cycles(latency, mode3) <= 4'(afe_setup_pkg::MAX_DELAY)) // RULE_05 RULE_06
      else $error("Latency beyond line depth");

   c_nibble_word:   cover property (dly_valid && fmt_sel == 2'b11 ##1 data_valid_o [*4]);
   c_auto_cycle:    cover property (advance ##[1:50] advance);
   c_soft_reset:    cover property (soft_rst);
   c_mode3_latency: cover property (mode3 && latency == 2'h3 && dly_valid);

endmodule // afe_output_and_clamp_setup

// ### bench/afe_host_model.sv
`timescale 1ns/1ps
// ************************************************************
// Host side of the register port
// ************************************************************
module afe_host_model (
   input  wire logic        clk_i,
   input  wire logic        pready_i,
   input  wire logic [31:0] prdata_i,
   input  wire logic        pslverr_i,
   output logic             psel_o,
   output logic             penable_o,
   output logic             pwrite_o,
   output logic      [7:0]  paddr_o,
   output logic      [31:0] pwdata_o
);
   initial begin
      psel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = 1'b0;
      paddr_o = 8'h00;
      pwdata_o = 32'h00000000;
   end
   // Never assumes a latency; the bound only catches a dead slave
   task automatic xfer(input logic w, input logic [5:0] idx, input logic [7:0] d,
                       output logic [31:0] rd, output logic err, output bit ok);
      int i;
      ok = 1'b0;
      rd = 32'h00000000;
      err = 1'b0;
      @(posedge clk_i);
      psel_o <= 1'b1;
      penable_o <= 1'b0;
      pwrite_o <= w;
      paddr_o <= {idx, 2'b00};
      pwdata_o <= {24'h000000, d};
      @(posedge clk_i);
      penable_o <= 1'b1;
      for (i = 0; i < 16 && !ok; i++) begin
         @(posedge clk_i);
         if (pready_i === 1'b1) begin
            ok = 1'b1;
            rd = prdata_i;
            err = pslverr_i;
         end
      end
      // Released lines show a changed value so stale data is not mistaken for live
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      paddr_o <= ~paddr_o;
      pwdata_o <= ~pwdata_o;
   endtask
endmodule // afe_host_model

// ### bench/afe_output_and_clamp_setup_test.sv
`timescale 1ns/1ps
module afe_output_and_clamp_setup_test;
   logic        clk_i, rst_b_i, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] sample_i, data_o;
   logic        sample_valid_i, mono_request_i, pin, data_valid_o, word_start_o;
   logic [3:0]  clamp_level_code_o;
   logic        clamp_dac_enable_o, clamp_dac_range_o, mono_mode_o, green_blue_gain_en_o, clamp_pulse_o;
   logic        device_reset_o;
   logic [1:0]  reset_sample_adjust_o, mono_channel_o, colour_sel_o;
   logic [7:0]  vals [4] = '{8'h00, 8'h5a, 8'ha5, 8'h3c};
   int          fail_count, n_tests, cnt;

   afe_output_and_clamp_setup DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata),
      .pslverr_o(pslverr), .sample_i(sample_i), .sample_valid_i(sample_valid_i),
      .mono_request_i(mono_request_i), .clamp_or_cycle_pin_i(pin), .data_o(data_o),
      .data_valid_o(data_valid_o), .word_start_o(word_start_o), .clamp_level_code_o(clamp_level_code_o),
      .clamp_dac_enable_o(clamp_dac_enable_o), .clamp_dac_range_o(clamp_dac_range_o),
      .reset_sample_adjust_o(reset_sample_adjust_o), .mono_mode_o(mono_mode_o),
      .mono_channel_o(mono_channel_o), .green_blue_gain_en_o(green_blue_gain_en_o),
      .colour_sel_o(colour_sel_o), .clamp_pulse_o(clamp_pulse_o), .device_reset_o(device_reset_o));
   afe_host_model HOST (.clk_i(clk_i), .pready_i(pready), .prdata_i(prdata), .pslverr_i(pslverr),
      .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));

   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic print_verdict;
      if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d, input logic [31:0] exp,
                      input logic experr);
      logic [31:0] rd;
      logic        err;
      bit          ok;
      HOST.xfer(w, idx, d, rd, err, ok);
      if (!ok) begin
         fail_count++;
         $display("[ERR] %0t bus answer missing", $time);
         print_verdict();
      end else begin
         if (!w) cmp(rd, exp);
         cmp({31'h00000000, err}, {31'h00000000, experr});
      end
   endtask
   task automatic settle;
      repeat (3) @(posedge clk_i);
      #1;
   endtask
   task automatic send(input logic [15:0] s, input int fmt, input int lat, input int per, input logic inv);
      logic [15:0] w, e;
      int          n, beats, k;
      w = inv ? ~s : s;
      beats = (fmt == 0) ? 1 : (fmt == 3) ? 4 : 2;
      @(posedge clk_i);
      sample_i <= s;
      sample_valid_i <= 1'b1;
      @(posedge clk_i);
      sample_valid_i <= 1'b0;
      #1;
      n = 1;
      while (n < 20 && data_valid_o !== 1'b1) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      if (n == 20) begin
         fail_count++;
         $display("[ERR] %0t output word missing", $time);
         print_verdict();
      end
      cmp(n, 1 + lat * per);
      cmp({31'h0, word_start_o}, 32'h1);
      for (k = 0; k < beats; k++) begin
         e = (fmt == 0) ? w : (fmt == 3) ? ((w >> (12 - 4 * k)) & 16'h000f) : ((w >> (8 - 8 * k)) & 16'h00ff);
         cmp({16'h0, data_o}, {16'h0, e});
         @(posedge clk_i);
         #1;
      end
      cmp({31'h0, data_valid_o}, 32'h0);
   endtask

   // ************************************************************
   // Stimulus
   // ************************************************************
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   initial begin
      rst_b_i = 1'b0;
      sample_i = 16'h0000;
      sample_valid_i = 1'b0;
      mono_request_i = 1'b0;
      pin = 1'b0;
      fail_count = 0;
      n_tests = 0;
      repeat (4) @(posedge clk_i);
      rst_b_i <= 1'b1;
      #1;
      cmp({19'h0, clamp_level_code_o, clamp_dac_enable_o, clamp_dac_range_o, reset_sample_adjust_o,
           green_blue_gain_en_o, mono_mode_o, colour_sel_o, device_reset_o}, 32'h1fb0);
      bus(1, afe_setup_pkg::IDX_DEVICE_RESET, 8'h00, 0, 0);
      bus(0, afe_setup_pkg::IDX_OUTPUT_FORMAT, 8'h00, 32'h20, 0);
      bus(0, afe_setup_pkg::IDX_CLAMP_CHANNEL, 8'h00, 32'h1f, 0);
      bus(0, afe_setup_pkg::IDX_DEVICE_RESET, 8'h00, 0, 0);
      bus(0, afe_setup_pkg::IDX_CYCLE_RESET, 8'h00, 0, 0);
      bus(1, 6'h3f, 8'hff, 0, 1);
      bus(0, 6'h3f, 8'h00, 0, 1);
      for (int f = 0; f < 4; f++) begin
         bus(1, afe_setup_pkg::IDX_OUTPUT_FORMAT, {f[1:0], 3'b100, f[0], f[1:0]}, 0, 0);
         settle();
         send(16'ha5c3, f, f, 2, f[0]);
      end
      bus(1, afe_setup_pkg::IDX_OUTPUT_FORMAT, 8'hff, 0, 0);
      bus(0, afe_setup_pkg::IDX_OUTPUT_FORMAT, 8'h00, 32'hef, 0);
      settle();
      cmp({30'h0, clamp_dac_enable_o, clamp_dac_range_o}, 32'h1);
      bus(1, afe_setup_pkg::IDX_LINE_MODE, 8'h04, 0, 0);
      bus(1, afe_setup_pkg::IDX_OUTPUT_FORMAT, 8'h80, 0, 0);
      settle();
      cmp({30'h0, clamp_dac_enable_o, clamp_dac_range_o}, 32'h2);
      send(16'h1234, 0, 2, 3, 1'b0);
      bus(1, afe_setup_pkg::IDX_LINE_MODE, 8'h00, 0, 0);
      // Channel code 11 is left out on purpose: its effect is undefined
      for (int i = 0; i < 4; i++) begin
         bus(1, afe_setup_pkg::IDX_CLAMP_CHANNEL, vals[i], 0, 0);
         settle();
         cmp({24'h0, mono_channel_o, reset_sample_adjust_o, clamp_level_code_o}, vals[i]);
         bus(0, afe_setup_pkg::IDX_CLAMP_CHANNEL, 8'h00, vals[i], 0);
      end
      @(posedge clk_i);
      mono_request_i <= 1'b1;
      settle();
      cmp({31'h0, mono_mode_o}, 32'h1);
      @(posedge clk_i);
      mono_request_i <= 1'b0;
      bus(1, afe_setup_pkg::IDX_CLAMP_CHANNEL, 8'ha5, 0, 0);
      bus(1, afe_setup_pkg::IDX_LINE_MODE, 8'h01, 0, 0);
      settle();
      cmp({28'h0, mono_mode_o, mono_channel_o, green_blue_gain_en_o}, 32'h8);
      pin <= 1'b1;
      repeat (6) @(posedge clk_i);
      #1;
      cmp({31'h0, clamp_pulse_o}, 32'h1);
      pin <= 1'b0;
      bus(1, afe_setup_pkg::IDX_LINE_MODE, 8'h03, 0, 0);
      settle();
      for (int k = 1; k < 5; k++) begin
         pin <= 1'b1;
         repeat (3) @(posedge clk_i);
         pin <= 1'b0;
         repeat (6) @(posedge clk_i);
         #1;
         cmp({30'h0, colour_sel_o}, k % 3);
         cmp({31'h0, clamp_pulse_o}, 32'h0);
      end
      bus(1, afe_setup_pkg::IDX_CYCLE_RESET, 8'h5a, 0, 0);
      settle();
      cmp({30'h0, colour_sel_o}, 32'h0);
      bus(1, afe_setup_pkg::IDX_OUTPUT_FORMAT, 8'hc3, 0, 0);
      bus(1, afe_setup_pkg::IDX_DEVICE_RESET, 8'hff, 0, 0);
      cnt = 0;
      #1;
      for (int i = 0; i < 4; i++) begin
         cnt += (device_reset_o === 1'b1);
         @(posedge clk_i);
         #1;
      end
      cmp(cnt, 1);
      bus(0, afe_setup_pkg::IDX_OUTPUT_FORMAT, 8'h00, 32'h20, 0);
      bus(0, afe_setup_pkg::IDX_CLAMP_CHANNEL, 8'h00, 32'h1f, 0);
      bus(0, afe_setup_pkg::IDX_LINE_MODE, 8'h00, 32'h00, 0);
      settle();
      cmp({19'h0, clamp_level_code_o, clamp_dac_enable_o, clamp_dac_range_o, reset_sample_adjust_o,
           green_blue_gain_en_o, mono_mode_o, colour_sel_o, device_reset_o}, 32'h1fb0);
      print_verdict();
   end
endmodule // afe_output_and_clamp_setup_test
